// ==== src/dssoc_regs.svh ====
// register offsets, field positions and reset values of the output control slice
// offsets are word indices: the bus byte address is four times the index
`ifndef DSSOC_REGS_SVH
`define DSSOC_REGS_SVH
`define DSSOC_IDX_PRIO_HI      8'h34
`define DSSOC_IDX_STATE_FLAGS  8'h35
`define DSSOC_IDX_OUT_ENABLES  8'h36
`define DSSOC_IDX_OUT_RUN      8'h37
`define DSSOC_IDX_IRQ_STATUS   8'h40
`define DSSOC_IDX_IRQ_ENABLE   8'h41
`define DSSOC_IDX_IRQ_CLEAR    8'h42
`define DSSOC_RST_PRIO_HI      8'h76
`define DSSOC_RST_STATE_FLAGS  8'h04
`define DSSOC_RST_OUT_ENABLES  8'h8f
`define DSSOC_RST_OUT_RUN      8'h0f
`define DSSOC_RST_IRQ_ENABLE   8'h00
`define DSSOC_BIT_HOLDOVER     0
`define DSSOC_BIT_LOCK         1
`define DSSOC_BIT_REF_FAIL     2
`define DSSOC_BIT_LOOP_CHOICE  6
`define DSSOC_BIT_SYNTH_ON     7
`define DSSOC_RANK_SIX_LO      0
`define DSSOC_RANK_SEVEN_LO    4
`define DSSOC_RESP_OKAY        2'b00
`define DSSOC_RESP_SLVERR      2'b10
`endif

// ==== src/dssoc_pkg.sv ====
// types shared by the output control slice
package dssoc_pkg;
	typedef logic [7:0] dssoc_byte_t;
	typedef logic [3:0] dssoc_rank_t;
	typedef struct packed {
		logic        aw_full;
		logic [7:0]  aw_idx;
		logic        w_full;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        b_valid;
		logic [1:0]  b_resp;
		logic        r_valid;
		logic [31:0] r_data;
		logic [1:0]  r_resp;
		logic [7:0]  prio_hi;
		logic [7:0]  enables;
		logic [7:0]  run;
		logic [2:0]  flags;
		logic [2:0]  irq_status;
		logic [2:0]  irq_enable;
	} dssoc_state_t;
endpackage : dssoc_pkg

// ==== src/dssoc_top.sv ====
// second loop status, rank register and synth_a output control over AXI4-Lite
// How it works
// - bits 7:4 hold input seven rank
// - status bit 0 shows second loop holdover
// - status bit 1 shows second loop locked
// - status bit 2 shows selected reference failure
// - enable bits 0,1 drive or float clocks
// - enable bits 2,3 drive or float pulses
// - enable bit 6 picks first/second loop
// - enable bit 7 switches synthesizer on
// - run bits 0,1 toggle clocks or hold low
// - run bits 2,3 pulse or hold low
// - bits 3:0 hold input six rank
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "dssoc_regs.svh"
module dssoc_top (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite slave
	input  wire logic [9:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [9:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// second loop state, from the loop engine (other domain)
	input  wire logic        second_loop_holdover,
	input  wire logic        second_loop_locked,
	input  wire logic        second_loop_ref_fail,
	// timing from the two loops (other domain)
	input  wire logic        first_loop_clock,
	input  wire logic        second_loop_clock,
	input  wire logic        first_loop_pulse,
	input  wire logic        second_loop_pulse,
	// rank fields for the reference selector
	output logic [3:0]       input_seven_rank,
	output logic [3:0]       input_six_rank,
	// synthesizer control
	output logic             synth_a_on,
	output logic             synth_a_loop_choice,
	// synth_a pins: [0]=clock zero [1]=clock one [2]=pulse zero [3]=pulse one
	output logic [3:0]       synth_a_pin_o,
	output logic [3:0]       synth_a_pin_oe,
	// interrupt
	output logic             irq
);
	dssoc_pkg::dssoc_state_t s_q;
	dssoc_pkg::dssoc_state_t s_d;
	logic [6:0] sync1_q;
	logic [6:0] sync2_q;
	logic [3:0] pin_q;
	logic [3:0] src;
	logic [2:0] flags_now;
	logic [7:0] rd_byte;
	logic [7:0] rd_idx;
	logic       rd_hit;
	logic       wr_go;
	logic       rd_go;

	// two-stage synchronisers for status and loop timing
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
		end
		else
		begin
			sync1_q <= {second_loop_pulse, first_loop_pulse,
				second_loop_clock, first_loop_clock,
				second_loop_ref_fail, second_loop_locked,
				second_loop_holdover};
			sync2_q <= sync1_q;
		end
	end

	assign flags_now = sync2_q[2:0];

	// source pick and synthesizer gating
	always_comb
	begin
		src = s_q.enables[`DSSOC_BIT_LOOP_CHOICE] ?
			{sync2_q[6], sync2_q[6], sync2_q[4], sync2_q[4]} :
			{sync2_q[5], sync2_q[5], sync2_q[3], sync2_q[3]};
		src = src & {4{s_q.enables[`DSSOC_BIT_SYNTH_ON]}};
		src = src & s_q.run[3:0];
	end

	// registered pin levels
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pin_q <= 4'h0;
		else
			pin_q <= src;
	end

	// pin drive: enable floats regardless of run
	assign synth_a_pin_o  = pin_q;
	assign synth_a_pin_oe = s_q.enables[3:0];

	assign input_seven_rank    = s_q.prio_hi[7:4];
	assign input_six_rank      = s_q.prio_hi[3:0];
	assign synth_a_on          = s_q.enables[`DSSOC_BIT_SYNTH_ON];
	assign synth_a_loop_choice = s_q.enables[`DSSOC_BIT_LOOP_CHOICE];
	assign irq = |(s_q.irq_status & s_q.irq_enable);

	// bus handshakes
	assign s_axi_awready = !s_q.aw_full;
	assign s_axi_wready  = !s_q.w_full;
	assign s_axi_arready = !s_q.r_valid;
	assign s_axi_bvalid  = s_q.b_valid;
	assign s_axi_bresp   = s_q.b_resp;
	assign s_axi_rvalid  = s_q.r_valid;
	assign s_axi_rdata   = s_q.r_data;
	assign s_axi_rresp   = s_q.r_resp;

	assign wr_go = s_q.aw_full && s_q.w_full && !s_q.b_valid;
	assign rd_go = s_axi_arvalid && !s_q.r_valid;

	// word index of the read request; byte lanes below it are ignored
	assign rd_idx = s_axi_araddr[9:2];

	// read decode
	always_comb
	begin
		rd_hit  = 1'b1;
		rd_byte = 8'h00;
		unique case (rd_idx)
			`DSSOC_IDX_PRIO_HI:     rd_byte = s_q.prio_hi;
			`DSSOC_IDX_STATE_FLAGS: rd_byte = {5'b0_0000, s_q.flags};
			`DSSOC_IDX_OUT_ENABLES: rd_byte = s_q.enables;
			`DSSOC_IDX_OUT_RUN:     rd_byte = s_q.run;
			`DSSOC_IDX_IRQ_STATUS:  rd_byte = {5'b0_0000, s_q.irq_status};
			`DSSOC_IDX_IRQ_ENABLE:  rd_byte = {5'b0_0000, s_q.irq_enable};
			`DSSOC_IDX_IRQ_CLEAR:   rd_byte = 8'h00;
			default:                rd_hit  = 1'b0;
		endcase
	end

	// next state
	always_comb
	begin
		s_d = s_q;
		// status flags follow the loop engine
		s_d.flags[`DSSOC_BIT_HOLDOVER] = flags_now[0];
		s_d.flags[`DSSOC_BIT_LOCK]     = flags_now[1];
		s_d.flags[`DSSOC_BIT_REF_FAIL] = flags_now[2];
		if (s_axi_awvalid && !s_q.aw_full)
		begin
			s_d.aw_full = 1'b1;
			s_d.aw_idx  = s_axi_awaddr[9:2];   // word index
		end
		if (s_axi_wvalid && !s_q.w_full)
		begin
			s_d.w_full = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		if (s_q.b_valid && s_axi_bready)
			s_d.b_valid = 1'b0;
		if (wr_go)
		begin
			s_d.aw_full = 1'b0;
			s_d.w_full  = 1'b0;
			s_d.b_valid = 1'b1;
			s_d.b_resp  = `DSSOC_RESP_OKAY;
			unique case (s_q.aw_idx)
				`DSSOC_IDX_PRIO_HI:
					if (s_q.w_strb[0]) s_d.prio_hi = s_q.w_data[7:0];
				`DSSOC_IDX_OUT_ENABLES:
					if (s_q.w_strb[0]) s_d.enables = s_q.w_data[7:0];
				`DSSOC_IDX_OUT_RUN:
					if (s_q.w_strb[0]) s_d.run = s_q.w_data[7:0];
				`DSSOC_IDX_IRQ_ENABLE:
					if (s_q.w_strb[0]) s_d.irq_enable = s_q.w_data[2:0];
				`DSSOC_IDX_IRQ_CLEAR:
					if (s_q.w_strb[0])
						s_d.irq_status = s_q.irq_status & ~s_q.w_data[2:0];
				`DSSOC_IDX_STATE_FLAGS, `DSSOC_IDX_IRQ_STATUS: ;
				default: s_d.b_resp = `DSSOC_RESP_SLVERR;
			endcase
		end
		// events: rising edge of each flag, set wins over clear
		s_d.irq_status = s_d.irq_status | (flags_now & ~s_q.flags);
		if (s_q.r_valid && s_axi_rready)
			s_d.r_valid = 1'b0;
		if (rd_go)
		begin
			s_d.r_valid = 1'b1;
			s_d.r_data  = {24'h00_0000, rd_byte};
			s_d.r_resp  = rd_hit ? `DSSOC_RESP_OKAY : `DSSOC_RESP_SLVERR;
		end
	end

	// state register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_q            <= '0;
			s_q.prio_hi    <= `DSSOC_RST_PRIO_HI;
			s_q.flags      <= 3'(`DSSOC_RST_STATE_FLAGS);
			s_q.enables    <= `DSSOC_RST_OUT_ENABLES;
			s_q.run        <= `DSSOC_RST_OUT_RUN;
			s_q.irq_enable <= 3'(`DSSOC_RST_IRQ_ENABLE);
		end
		else
			s_q <= s_d;
	end

	// committed enable writes reach the pin enables one cycle later
	a_pin_enable: assert property (
		@(posedge aclk) disable iff (!aresetn)
		wr_go && s_q.aw_idx == `DSSOC_IDX_OUT_ENABLES && s_q.w_strb[0]
		|=> synth_a_pin_oe[1:0] == $past(s_q.w_data[1:0]))
		else $error("clock enables differ from written value");

	a_pulse_enable: assert property (
		@(posedge aclk) disable iff (!aresetn)
		wr_go && s_q.aw_idx == `DSSOC_IDX_OUT_ENABLES && s_q.w_strb[0]
		|=> synth_a_pin_oe[3:2] == $past(s_q.w_data[3:2]))
		else $error("pulse enables differ from written value");

	// a cleared run bit holds its output low from the next cycle
	a_clock_stop: assert property (
		@(posedge aclk) disable iff (!aresetn)
		!s_q.run[0] |=> !synth_a_pin_o[0])
		else $error("clock zero runs while stopped");

	a_clock_one_stop: assert property (
		@(posedge aclk) disable iff (!aresetn)
		!s_q.run[1] |=> !synth_a_pin_o[1])
		else $error("clock one runs while stopped");

	a_pulse_stop: assert property (
		@(posedge aclk) disable iff (!aresetn)
		!s_q.run[2] |=> !synth_a_pin_o[2])
		else $error("pulse zero runs while stopped");

	a_pulse_one_stop: assert property (
		@(posedge aclk) disable iff (!aresetn)
		!s_q.run[3] |=> !synth_a_pin_o[3])
		else $error("pulse one runs while stopped");

	// run bits land as written
	a_run_write: assert property (
		@(posedge aclk) disable iff (!aresetn)
		wr_go && s_q.aw_idx == `DSSOC_IDX_OUT_RUN && s_q.w_strb[0]
		|=> s_q.run == $past(s_q.w_data[7:0]))
		else $error("run register differs from written value");

	// synthesizer off silences every pin
	a_synth_off: assert property (
		@(posedge aclk) disable iff (!aresetn)
		!s_q.enables[`DSSOC_BIT_SYNTH_ON] |=> synth_a_pin_o == 4'h0)
		else $error("output active with synthesizer off");

	// the loop choice decides which timing reaches the pins
	a_loop_pick: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s_q.enables[7] && s_q.run[0] && s_q.enables[6]
		|=> synth_a_pin_o[0] == $past(sync2_q[4]))
		else $error("wrong loop drives clock zero");

	a_first_pick: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s_q.enables[7] && s_q.run[0] && !s_q.enables[6]
		|=> synth_a_pin_o[0] == $past(sync2_q[3]))
		else $error("first loop does not drive clock zero");

	a_pulse_pick: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s_q.enables[7] && s_q.run[2] && s_q.enables[6]
		|=> synth_a_pin_o[2] == $past(sync2_q[6]))
		else $error("wrong loop drives pulse zero");

	// status bits follow the synchronised loop state
	a_hold_flag: assert property (
		@(posedge aclk) disable iff (!aresetn)
		sync2_q[0] |=> s_q.flags[0])
		else $error("holdover flag missed");

	a_lock_flag: assert property (
		@(posedge aclk) disable iff (!aresetn)
		sync2_q[1] ##1 sync2_q[1] |-> s_q.flags[1])
		else $error("lock flag missed");

	a_fail_flag: assert property (
		@(posedge aclk) disable iff (!aresetn)
		aresetn && !sync2_q[2] |=> !s_q.flags[2])
		else $error("fail flag stuck");

	a_fail_set: assert property (
		@(posedge aclk) disable iff (!aresetn)
		sync2_q[2] |=> s_q.flags[2])
		else $error("fail flag missed");

	// a rising state sets its sticky event, even against a clear
	a_event_set: assert property (
		@(posedge aclk) disable iff (!aresetn)
		flags_now[0] && !s_q.flags[0] |=> s_q.irq_status[0])
		else $error("holdover event lost");

	// committed rank writes reach the selector outputs
	a_rank_fields: assert property (
		@(posedge aclk) disable iff (!aresetn)
		wr_go && s_q.aw_idx == `DSSOC_IDX_PRIO_HI && s_q.w_strb[0]
		|=> {input_seven_rank, input_six_rank}
			== $past(s_q.w_data[7:0]))
		else $error("rank outputs differ from written value");

	// a floated output stays floated whatever its run bit says
	a_float_wins: assert property (
		@(posedge aclk) disable iff (!aresetn)
		!s_q.enables[1] && s_q.run[1] |-> !synth_a_pin_oe[1])
		else $error("disabled output driven");

	// bus answers follow their requests
	a_resp_follows: assert property (
		@(posedge aclk) disable iff (!aresetn)
		wr_go |=> s_axi_bvalid)
		else $error("write response missing");

	a_read_answer: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing");

	a_read_err: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && !rd_hit
		|=> s_axi_rresp == `DSSOC_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");

	a_read_pad: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
endmodule : dssoc_top

// ==== verif/dssoc_top_test.sv ====
// self-checking bench of the output control slice
`timescale 1ns/1ns
`define CHK(g, e) \
	begin \
		n_compared++; \
		if ((g) !== (e)) \
			$display("Error at %0t: got %h want %h", $time, g, e); \
		if ((g) !== (e)) \
			failures++; \
	end
module dssoc_top_test;
	logic        aclk, aresetn;
	logic [9:0]  awaddr, araddr;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic        hold, lock, fail, c1, c2, p1, p2;
	logic [3:0]  rank7, rank6, pin_o, pin_oe;
	logic        on, choice, irq;
	int          failures, n_compared;

	// clock at 250 MHz
	always #2 aclk = ~aclk;

	dssoc_top dssoc_top_inst (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.second_loop_holdover(hold), .second_loop_locked(lock),
		.second_loop_ref_fail(fail), .first_loop_clock(c1),
		.second_loop_clock(c2), .first_loop_pulse(p1),
		.second_loop_pulse(p2), .input_seven_rank(rank7),
		.input_six_rank(rank6), .synth_a_on(on),
		.synth_a_loop_choice(choice), .synth_a_pin_o(pin_o),
		.synth_a_pin_oe(pin_oe), .irq(irq)
	);

	task automatic end_of_test;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test

	// write by word index: each item held until the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		logic pa, pw, pb;
		pa = 1'b1;
		pw = 1'b1;
		pb = 1'b1;
		r  = 'x;
		// one edge between transfers so no strobe is driven twice at once
		@(posedge aclk);
		awaddr  <= {a, 2'b00};
		wdata   <= d;
		wstrb   <= 4'hf;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (n = 0; pb && n < 100; n++)
		begin
			@(posedge aclk);
			if (pa && awready)
			begin
				pa = 1'b0;
				awvalid <= 1'b0;
			end
			if (pw && wready)
			begin
				pw = 1'b0;
				wvalid <= 1'b0;
			end
			if (bvalid)
			begin
				pb = 1'b0;
				r  = bresp;
				bready <= 1'b0;
			end
		end
		if (pb)
		begin
			failures++;
			end_of_test;
		end
	endtask : wr

	// read by word index: answer taken at the edge where it stands
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		logic pa, pr;
		pa = 1'b1;
		pr = 1'b1;
		d  = 'x;
		r  = 'x;
		@(posedge aclk);
		araddr  <= {a, 2'b00};
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (n = 0; pr && n < 100; n++)
		begin
			@(posedge aclk);
			if (pa && arready)
			begin
				pa = 1'b0;
				arvalid <= 1'b0;
			end
			if (rvalid)
			begin
				pr = 1'b0;
				d  = rdata;
				r  = rresp;
				rready <= 1'b0;
			end
		end
		if (pr)
		begin
			failures++;
			end_of_test;
		end
	endtask : rd

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		`CHK(d, e)
		`CHK(r, 2'b00)
	endtask : rd_chk

	task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		`CHK(r, 2'b00)
	endtask : wr_ok

	// lets the input synchronisers and output registers catch up
	task automatic settle;
		repeat (5) @(posedge aclk);
	endtask : settle

	task automatic t_reset;
		rd_chk(8'h34, 32'h0000_0076);
		`CHK(rank7, 4'h7)
		`CHK(rank6, 4'h6)
		rd_chk(8'h35, 32'h0000_0004);
		rd_chk(8'h36, 32'h0000_008f);
		rd_chk(8'h37, 32'h0000_000f);
		`CHK(pin_oe, 4'hf)
		`CHK(pin_o, 4'h0)
		`CHK(irq, 1'b0)
		`CHK(on, 1'b1)
		`CHK(choice, 1'b0)
	endtask : t_reset

	task automatic t_rank;
		wr_ok(8'h34, 32'h0000_00f0);
		`CHK(rank7, 4'hf)
		`CHK(rank6, 4'h0)
		rd_chk(8'h34, 32'h0000_00f0);
	endtask : t_rank

	task automatic t_flags;
		hold <= 1'b1; lock <= 1'b1; fail <= 1'b0;
		settle;
		rd_chk(8'h35, 32'h0000_0003);
		hold <= 1'b0; lock <= 1'b0; fail <= 1'b1;
		settle;
		wr_ok(8'h35, 32'h0000_00ff);
		rd_chk(8'h35, 32'h0000_0004);
	endtask : t_flags

	// sticky events, mask and clear
	task automatic t_irq;
		wr_ok(8'h42, 32'h0000_0007);
		wr_ok(8'h41, 32'h0000_0002);
		hold <= 1'b1;
		settle;
		`CHK(irq, 1'b0)
		rd_chk(8'h40, 32'h0000_0001);
		lock <= 1'b1;
		settle;
		`CHK(irq, 1'b1)
		wr_ok(8'h42, 32'h0000_0002);
		settle;
		`CHK(irq, 1'b0)
	endtask : t_irq

	task automatic t_pins;
		c1 <= 1'b1;
		settle;
		`CHK(pin_o, 4'b0011)
		wr_ok(8'h37, 32'h0000_000e);
		settle;
		`CHK(pin_o, 4'b0010)
		wr_ok(8'h37, 32'h0000_000f);
		wr_ok(8'h36, 32'h0000_00cf);
		p2 <= 1'b1;
		settle;
		`CHK(choice, 1'b1)
		`CHK(pin_o, 4'b1100)
		wr_ok(8'h37, 32'h0000_000b);
		settle;
		`CHK(pin_o, 4'b1000)
		wr_ok(8'h36, 32'h0000_0085);
		settle;
		`CHK(pin_oe, 4'h5)
		`CHK(pin_oe[1], 1'b0)
		`CHK(pin_o, 4'b0011)
		wr_ok(8'h36, 32'h0000_0005);
		settle;
		`CHK(on, 1'b0)
		`CHK(pin_o, 4'b0000)
	endtask : t_pins

	// unmapped place answers with an error
	task automatic t_unmapped;
		logic [31:0] d;
		logic [1:0]  r;
		rd(8'h50, d, r);
		`CHK(r, 2'b10)
		`CHK(d, 32'h0000_0000)
		wr(8'h50, 32'h0000_00ff, r);
		`CHK(r, 2'b10)
	endtask : t_unmapped

	initial
	begin
		aclk = 0; aresetn = 0; failures = 0; n_compared = 0;
		awaddr = 0; araddr = 0; wdata = 0; wstrb = 0;
		awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
		hold = 0; lock = 0; fail = 1; c1 = 0; c2 = 0; p1 = 0; p2 = 0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_rank;
		t_flags;
		t_irq;
		t_pins;
		t_unmapped;
		end_of_test;
	end
endmodule : dssoc_top_test
